/* File: core/dbs_boot_seq.sv */
// Purpose: master side boot sequencer for a dual processor device
// Assumes: rst covers every master reset source; straps are synchronous
// Notes: loaders and flash checks are external; handshakes are levels
//
// Overview of operation
// - any master reset restarts the whole boot sequence
// - boot begins as reset drops; control and analog stay held in reset
// - order: device init, master init, then release control and analog
// - control boot runs in parallel once released, never waits on master
// - control side idles after its init until wake interrupt channel 1
// - after release, sample strap3..strap0 as the boot mode number
// - mode 0 loads through the parallel gpio loader
// - mode 1 branches into master ram with no load
// - mode 2 loads through uart, sync serial or i2c as slave
// - mode 3 loads through the master can interface
// - modes 4 and 12 load via ethernet, on different pin sets
// - mode 9 sync serial master load, mode 10 i2c master load
// - modes 5, 6, 8, 11, 13 and 14 fall back to flash boot
// - modes 7 and 15 branch to flash; invalid image faults and restarts
// - only mode 15 applies the fast flash power-up setup
// - control leaves idle on master to control wake interrupt 1
`timescale 1ns/1ps
`default_nettype none
`include "dbs_regs.svh"

module dbs_boot_seq #(
    parameter logic [7:0] INIT_CYCLES = `DBS_INIT_CYCLES
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // strap pins
    input wire logic strap3_pin,
    input wire logic strap2_pin,
    input wire logic strap1_pin,
    input wire logic strap0_pin,
    // loader handshake
    input wire logic load_done,
    input wire logic flash_valid,
    // control side handshake
    input wire logic control_init_done,
    input wire logic master_to_control_wake_int,
    // reset releases
    output logic control_rst_q,
    output logic analog_rst_q,
    // loader selection
    output dbs_pkg::dbs_src_e load_src_q,
    output logic enet_alt_pins_q,
    output logic fast_flash_cfg_q,
    output logic hard_fault_q,
    // status
    output logic control_idle_q,
    output logic boot_done_q,
    output dbs_pkg::dbs_tgt_e branch_tgt_q,
    output logic [3:0] boot_mode_q
);

    // ***************************************************************
    // helpers
    // ***************************************************************
    // loader for a mode; NONE means branch without a load
    function automatic dbs_pkg::dbs_src_e mode_src(input logic [3:0] m);
        unique case (m)
            `DBS_MODE_PARALLEL: mode_src = dbs_pkg::DBS_SRC_PARALLEL;
            `DBS_MODE_SERIAL_SLAVE:
                mode_src = dbs_pkg::DBS_SRC_SERIAL_SLAVE;
            `DBS_MODE_CAN: mode_src = dbs_pkg::DBS_SRC_CAN;
            `DBS_MODE_ENET_A,
            `DBS_MODE_ENET_B: mode_src = dbs_pkg::DBS_SRC_ENET;
            `DBS_MODE_SSI_MASTER:
                mode_src = dbs_pkg::DBS_SRC_SSI_MASTER;
            `DBS_MODE_I2C_MASTER:
                mode_src = dbs_pkg::DBS_SRC_I2C_MASTER;
            default: mode_src = dbs_pkg::DBS_SRC_NONE;
        endcase
    endfunction : mode_src

    // ***************************************************************
    // sequencer
    // ***************************************************************
    dbs_pkg::dbs_state_e state_q;
    logic [7:0] cnt_q;
    logic [3:0] strap_mode;

    assign strap_mode = {strap3_pin, strap2_pin, strap1_pin, strap0_pin};

    // init steps are timed; flash fault loops back to device init
    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_q <= dbs_pkg::DBS_ST_DEV_INIT;
            cnt_q <= 8'h00;
        end else begin
            unique case (state_q)
                dbs_pkg::DBS_ST_DEV_INIT: begin
                    cnt_q <= cnt_q + 8'h01;
                    if (cnt_q == INIT_CYCLES - 8'h01) begin
                        cnt_q <= 8'h00;
                        state_q <= dbs_pkg::DBS_ST_MST_INIT;
                    end
                end
                dbs_pkg::DBS_ST_MST_INIT: begin
                    cnt_q <= cnt_q + 8'h01;
                    if (cnt_q == INIT_CYCLES - 8'h01) begin
                        cnt_q <= 8'h00;
                        state_q <= dbs_pkg::DBS_ST_RELEASE;
                    end
                end
                dbs_pkg::DBS_ST_RELEASE: state_q <= dbs_pkg::DBS_ST_SAMPLE;
                dbs_pkg::DBS_ST_SAMPLE: begin
                    if (mode_src(strap_mode) != dbs_pkg::DBS_SRC_NONE) begin
                        state_q <= dbs_pkg::DBS_ST_LOAD;
                    end else if (strap_mode == `DBS_MODE_RAM) begin
                        state_q <= dbs_pkg::DBS_ST_DONE;
                    end else begin
                        state_q <= dbs_pkg::DBS_ST_FLASH_CHK;
                    end
                end
                dbs_pkg::DBS_ST_LOAD: begin
                    if (load_done) begin
                        state_q <= dbs_pkg::DBS_ST_DONE;
                    end
                end
                dbs_pkg::DBS_ST_FLASH_CHK: begin
                    if (flash_valid) begin
                        state_q <= dbs_pkg::DBS_ST_DONE;
                    end else begin
                        state_q <= dbs_pkg::DBS_ST_DEV_INIT;
                    end
                end
                dbs_pkg::DBS_ST_DONE: state_q <= dbs_pkg::DBS_ST_DONE;
                default: state_q <= dbs_pkg::DBS_ST_DEV_INIT;
            endcase
        end
    end

    // ***************************************************************
    // reset releases
    // ***************************************************************
    // held until master init ends; re-held when a fault restarts boot
    always_ff @(posedge core_clk) begin
        if (rst) begin
            control_rst_q <= 1'b1;
            analog_rst_q <= 1'b1;
        end else if (state_q == dbs_pkg::DBS_ST_RELEASE) begin
            control_rst_q <= 1'b0;
            analog_rst_q <= 1'b0;
        end else if (state_q == dbs_pkg::DBS_ST_DEV_INIT) begin
            control_rst_q <= 1'b1;
            analog_rst_q <= 1'b1;
        end
    end

    // remembers the wake; init done stays high, so a pulsed wake would
    // otherwise drop the control side straight back into idle
    logic woken_q;

    always_ff @(posedge core_clk) begin
        if (rst || control_rst_q) begin
            woken_q <= 1'b0;
        end else if (control_idle_q && master_to_control_wake_int) begin
            woken_q <= 1'b1;
        end
    end

    // control idles after its own init, independent of master progress
    always_ff @(posedge core_clk) begin
        if (rst || control_rst_q) begin
            control_idle_q <= 1'b0;
        end else if (control_idle_q && master_to_control_wake_int) begin
            control_idle_q <= 1'b0;
        end else if (control_init_done && !woken_q
            && !master_to_control_wake_int) begin
            control_idle_q <= 1'b1;
        end
    end

    // ***************************************************************
    // mode capture and loader selection
    // ***************************************************************
    // sampled once per pass; later strap motion ignored until reset or a fault restart
    always_ff @(posedge core_clk) begin
        if (rst) begin
            boot_mode_q <= `DBS_MODE_RST;
            load_src_q <= dbs_pkg::DBS_SRC_NONE;
            enet_alt_pins_q <= 1'b0;
            fast_flash_cfg_q <= 1'b0;
            branch_tgt_q <= dbs_pkg::DBS_TGT_FLASH;
        end else if (state_q == dbs_pkg::DBS_ST_SAMPLE) begin
            boot_mode_q <= strap_mode;
            load_src_q <= mode_src(strap_mode);
            enet_alt_pins_q <= (strap_mode == `DBS_MODE_ENET_B);
            fast_flash_cfg_q <= (strap_mode == `DBS_MODE_FAST_FLASH);
            if (mode_src(strap_mode) != dbs_pkg::DBS_SRC_NONE) begin
                branch_tgt_q <= dbs_pkg::DBS_TGT_LOADED;
            end else if (strap_mode == `DBS_MODE_RAM) begin
                branch_tgt_q <= dbs_pkg::DBS_TGT_RAM;
            end else begin
                branch_tgt_q <= dbs_pkg::DBS_TGT_FLASH;
            end
        end
    end

    // ***************************************************************
    // fault and done
    // ***************************************************************
    // fault pulses one cycle as the sequence loops back
    always_ff @(posedge core_clk) begin
        if (rst) begin
            hard_fault_q <= 1'b0;
            boot_done_q <= 1'b0;
        end else begin
            hard_fault_q <= (state_q == dbs_pkg::DBS_ST_FLASH_CHK)
                && !flash_valid;
            boot_done_q <= (state_q == dbs_pkg::DBS_ST_DONE);
        end
    end

    // ***************************************************************
    // checks
    // ***************************************************************
    a_rst_holds_sub: assert property (
        @(posedge core_clk) disable iff (rst)
        (state_q == dbs_pkg::DBS_ST_DEV_INIT
        || state_q == dbs_pkg::DBS_ST_MST_INIT)
        |=> control_rst_q && analog_rst_q)
        else $error("subsystems released before master init ended");
    a_release_order: assert property (
        @(posedge core_clk) disable iff (rst)
        $fell(control_rst_q) |-> $past(state_q) == dbs_pkg::DBS_ST_RELEASE)
        else $error("control released out of order");
    a_mode_sampled: assert property (
        @(posedge core_clk) disable iff (rst)
        state_q == dbs_pkg::DBS_ST_SAMPLE |=>
        boot_mode_q == $past(strap_mode))
        else $error("boot mode not the strap value");
    a_mode_held: assert property (
        @(posedge core_clk) disable iff (rst)
        boot_done_q |=> $stable(boot_mode_q))
        else $error("boot mode changed after boot");
    a_fast_only_15: assert property (
        @(posedge core_clk) disable iff (rst)
        fast_flash_cfg_q |-> boot_mode_q == `DBS_MODE_FAST_FLASH)
        else $error("fast flash set for wrong mode");
    // the fault pulse shows as the state loops back; resets follow a cycle on
    a_fault_restart: assert property (
        @(posedge core_clk) disable iff (rst)
        hard_fault_q |-> state_q == dbs_pkg::DBS_ST_DEV_INIT
        ##1 (control_rst_q && analog_rst_q))
        else $error("fault did not restart boot");
    a_ram_no_load: assert property (
        @(posedge core_clk) disable iff (rst)
        (state_q == dbs_pkg::DBS_ST_SAMPLE && strap_mode == `DBS_MODE_RAM)
        |=> ##1 boot_done_q && branch_tgt_q == dbs_pkg::DBS_TGT_RAM
        && load_src_q == dbs_pkg::DBS_SRC_NONE)
        else $error("ram boot did not branch");
    a_wake_idle: assert property (
        @(posedge core_clk) disable iff (rst)
        control_idle_q && master_to_control_wake_int |=> !control_idle_q)
        else $error("control did not wake");
    a_fallback_flash: assert property (
        @(posedge core_clk) disable iff (rst)
        (state_q == dbs_pkg::DBS_ST_SAMPLE && strap_mode == 4'h8)
        |=> state_q == dbs_pkg::DBS_ST_FLASH_CHK)
        else $error("unsupported mode not falling back to flash");

endmodule : dbs_boot_seq
`default_nettype wire

/* File: core/dbs_pkg.sv */
// Purpose: types for the dual core boot sequencer
// Assumes: nothing
// Notes: load source and sequencer states
package dbs_pkg;
    typedef enum logic [2:0] {
        DBS_SRC_NONE,
        DBS_SRC_PARALLEL,
        DBS_SRC_SERIAL_SLAVE,
        DBS_SRC_CAN,
        DBS_SRC_ENET,
        DBS_SRC_SSI_MASTER,
        DBS_SRC_I2C_MASTER
    } dbs_src_e;
    typedef enum logic [1:0] {
        DBS_TGT_RAM,
        DBS_TGT_FLASH,
        DBS_TGT_LOADED
    } dbs_tgt_e;
    typedef enum logic [2:0] {
        DBS_ST_DEV_INIT,
        DBS_ST_MST_INIT,
        DBS_ST_RELEASE,
        DBS_ST_SAMPLE,
        DBS_ST_LOAD,
        DBS_ST_FLASH_CHK,
        DBS_ST_DONE
    } dbs_state_e;
endpackage : dbs_pkg

/* File: core/dbs_regs.svh */
// Purpose: constants for the dual core boot sequencer
// Assumes: 200 MHz core clock
// Notes: boot mode codes as strapped, strap3 most significant
`ifndef DBS_REGS_SVH
`define DBS_REGS_SVH
// ***************************************************************
// boot mode codes
// ***************************************************************
`define DBS_MODE_PARALLEL 4'h0
`define DBS_MODE_RAM 4'h1
`define DBS_MODE_SERIAL_SLAVE 4'h2
`define DBS_MODE_CAN 4'h3
`define DBS_MODE_ENET_A 4'h4
`define DBS_MODE_FLASH 4'h7
`define DBS_MODE_SSI_MASTER 4'h9
`define DBS_MODE_I2C_MASTER 4'hA
`define DBS_MODE_ENET_B 4'hC
`define DBS_MODE_FAST_FLASH 4'hF
// ***************************************************************
// step timing and reset boot mode
// ***************************************************************
`define DBS_INIT_CYCLES 8'h04
`define DBS_MODE_RST 4'h0
`endif

/* File: dv/dbs_board_model.sv */
// Purpose: board straps, debugger and loader stand-in for the boot sequencer
// Assumes: every strap is driven by the board, none float
// Notes: straps move after sampling so the mode hold gets exercised
`timescale 1ns/1ps
`default_nettype none

module dbs_board_model (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // bench controls
    input wire logic [3:0] mode_sel,
    input wire logic [7:0] load_delay,
    // sequencer outputs watched
    input wire logic control_rst_q,
    input wire dbs_pkg::dbs_src_e load_src_q,
    // lines driven back
    output wire logic strap3_pin,
    output wire logic strap2_pin,
    output wire logic strap1_pin,
    output wire logic strap0_pin,
    output wire logic load_done,
    output wire logic control_init_done
);
    // ************************************************************
    // counters
    // ************************************************************
    logic [7:0] rel_cnt = 8'h00;
    logic [7:0] ld_cnt = 8'h00;

    // cycles since control release and since a loader was chosen
    always @(negedge core_clk) begin
        if (rst || control_rst_q !== 1'b0) rel_cnt <= 8'h00;
        else if (rel_cnt != 8'hff) rel_cnt <= rel_cnt + 8'h01;
        if (rst || load_src_q == dbs_pkg::DBS_SRC_NONE) ld_cnt <= 8'h00;
        else if (ld_cnt != 8'hff) ld_cnt <= ld_cnt + 8'h01;
    end

    // straps always at a firm level; the debugger moves them late
    // the bench clock stands for the 200 MHz core clock
    assign {strap3_pin, strap2_pin, strap1_pin, strap0_pin} =
        (rel_cnt > 8'h03) ? ~mode_sel : mode_sel;
    assign load_done = (ld_cnt >= load_delay);
    assign control_init_done = (rel_cnt >= 8'h03);
endmodule : dbs_board_model

`default_nettype wire

/* File: dv/dbs_boot_seq_tb_top.sv */
// Purpose: self-checking bench for the boot sequencer
// Assumes: default init length, loader delays drawn at random
// Notes: expected outcomes queue up and are matched as results appear
`timescale 1ns/1ps
`default_nettype none

module dbs_boot_seq_tb_top;
    typedef struct packed {
        logic [3:0] mode;
        dbs_pkg::dbs_src_e src;
        dbs_pkg::dbs_tgt_e tgt;
        logic fast;
        logic alt;
        logic fault;
    } dbs_exp_s;
    logic core_clk, rst, flash_valid, wake, load_done, init_done;
    logic s3, s2, s1, s0, ctl_rst, ana_rst, alt, fast, fault, idle, done;
    logic done_prev;
    logic [3:0] mode_sel, boot_mode;
    logic [7:0] load_delay;
    dbs_pkg::dbs_src_e src;
    dbs_pkg::dbs_tgt_e tgt;
    dbs_exp_s exp_q[$];
    dbs_exp_s e;
    int err_count = 0;
    int n_tests = 0;
    int seed = 32'h7022206b;

    dbs_boot_seq #(.INIT_CYCLES(8'h04)) i_dbs_boot_seq (.core_clk(core_clk),
        .rst(rst), .strap3_pin(s3), .strap2_pin(s2), .strap1_pin(s1),
        .strap0_pin(s0), .load_done(load_done), .flash_valid(flash_valid),
        .control_init_done(init_done), .master_to_control_wake_int(wake),
        .control_rst_q(ctl_rst), .analog_rst_q(ana_rst), .load_src_q(src),
        .enet_alt_pins_q(alt), .fast_flash_cfg_q(fast), .hard_fault_q(fault),
        .control_idle_q(idle), .boot_done_q(done), .branch_tgt_q(tgt),
        .boot_mode_q(boot_mode));
    dbs_board_model i_dbs_board_model (.core_clk(core_clk), .rst(rst),
        .mode_sel(mode_sel), .load_delay(load_delay), .control_rst_q(ctl_rst),
        .load_src_q(src), .strap3_pin(s3), .strap2_pin(s2), .strap1_pin(s1),
        .strap0_pin(s0), .load_done(load_done), .control_init_done(init_done));

    // ************************************************************
    // helpers
    // ************************************************************
    task automatic check(input string name, input logic [3:0] seen,
                         input logic [3:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task conclude;
        check("leftover", 4'(exp_q.size()), 4'h0);
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : conclude

    // bounded step: a hang counts as a mismatch and ends the run
    task automatic step(inout int k);
        @(negedge core_clk);
        k++;
        if (k > 400) begin
            err_count++;
            $display("CHECK FAILED wait expected end seen timeout");
            conclude();
        end
    endtask : step

    // expected outcome worked out from the strap code
    function automatic dbs_exp_s exp_of(input logic [3:0] m, input logic f);
        dbs_exp_s r;
        r = '{m, dbs_pkg::DBS_SRC_NONE, dbs_pkg::DBS_TGT_FLASH, m == 4'hf,
              m == 4'hc, f};
        case (m)
            4'h0: r.src = dbs_pkg::DBS_SRC_PARALLEL;
            4'h2: r.src = dbs_pkg::DBS_SRC_SERIAL_SLAVE;
            4'h3: r.src = dbs_pkg::DBS_SRC_CAN;
            4'h4, 4'hc: r.src = dbs_pkg::DBS_SRC_ENET;
            4'h9: r.src = dbs_pkg::DBS_SRC_SSI_MASTER;
            4'ha: r.src = dbs_pkg::DBS_SRC_I2C_MASTER;
            default: r.src = dbs_pkg::DBS_SRC_NONE;
        endcase
        if (m == 4'h1) begin
            r.tgt = dbs_pkg::DBS_TGT_RAM;
        end else if (r.src != dbs_pkg::DBS_SRC_NONE) begin
            r.tgt = dbs_pkg::DBS_TGT_LOADED;
        end
        return r;
    endfunction : exp_of

    // one boot from reset; good low means a blank flash first
    task automatic boot(input logic [3:0] m, input logic good);
        int k, rel;
        @(negedge core_clk);
        rst = 1'b1;
        mode_sel = m;
        flash_valid = good;
        wake = 1'b0;
        load_delay = 8'h05 + 8'($random(seed) & 15);
        repeat (4) @(negedge core_clk);
        check("held", {2'b00, ctl_rst, ana_rst}, 4'h3);
        if (!good) exp_q.push_back(exp_of(m, 1'b1));
        exp_q.push_back(exp_of(m, 1'b0));
        rst = 1'b0;
        rel = 0;
        while (ctl_rst !== 1'b0) step(rel);
        check("analog", {3'b000, ana_rst}, 4'h0);
        check("order", {3'b000, rel >= 9}, 4'h1);
        if (!good) begin
            k = 0;
            while (ctl_rst !== 1'b1) step(k);
            flash_valid = 1'b1;
            while (ctl_rst !== 1'b0) step(k);
        end
        k = 0;
        while (done !== 1'b1) step(k);
        if (m == 4'h1) check("ram_lat", 4'(k), 4'h2);
        repeat (3) @(negedge core_clk);
        check("idle", {3'b000, idle}, 4'h1);
        wake = 1'b1;
        @(negedge core_clk);
        check("wake", {3'b000, idle}, 4'h0);
        check("hold", boot_mode, m);
        // wake drops again: the control side must not fall back into idle
        wake = 1'b0;
        @(negedge core_clk);
        check("stay_awake", {3'b000, idle}, 4'h0);
        $display("boot mode %0d finished", m);
    endtask : boot

    // ************************************************************
    // clock, stimulus and result watcher
    // ************************************************************
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    initial begin
        rst = 1'b1;
        mode_sel = 4'h0;
        load_delay = 8'h05;
        flash_valid = 1'b1;
        wake = 1'b0;
        for (int m = 0; m < 16; m++) boot(4'(m), 1'b1);
        boot(4'h7, 1'b0);
        boot(4'hf, 1'b0);
        conclude();
    end

    // take the oldest note as each done or fault shows up
    always @(negedge core_clk) begin
        if ((done === 1'b1 && done_prev !== 1'b1) || fault === 1'b1) begin
            if (exp_q.size() == 0) check("spurious", 4'h1, 4'h0);
            else begin
                e = exp_q.pop_front();
                check("mode", boot_mode, e.mode);
                check("src", 4'(src), 4'(e.src));
                check("tgt", 4'(tgt), 4'(e.tgt));
                check("fast", {3'b000, fast}, {3'b000, e.fast});
                check("alt", {3'b000, alt}, {3'b000, e.alt});
                check("fault", {3'b000, fault}, {3'b000, e.fault});
                check("done", {3'b000, done}, {3'b000, ~e.fault});
            end
        end
        done_prev = done;
    end
endmodule : dbs_boot_seq_tb_top

`default_nettype wire
